// ---- rtl/delay_timer_pkg.sv ----
// Constants shared by the commutation delay timer.
// Operation
// - Autoswitch bit picks switched or autoswitched mode
// - Switched: compare match commutates, clears timer
// - Commutation loads preload, sets flag, may interrupt
// - Ratio field writable only with clock disabled
// - Switched: ratio flags shift prescaler at commutation
// - Writing both ratio flags together is ignored
// - Switched: zero crossings leave timer untouched
// - Switched: overflow wraps, flag if edge select 00
// - Autoswitched: commutation leaves timer count unchanged
// - Zero crossing captures timer, shifts capture, clears
// - Simulated crossing shifts written capture, clears timer
// - Compare is weight times chosen capture over 256
// - Compare not above timer commutates at once
// - Soft commutation compares only after compare write
// - Soft commutation allows back to back commutations
// - Soft commutation still honours zero crossings
// - Timer reaching 100h raises prescaler, halves registers
// - Crossing below 55h lowers prescaler, doubles registers
// - Prescaler zero suppresses automatic decrement
// - Prescaler fifteen wraps timer without ratio change
// - Captures hold interval between zero crossings
package delay_timer_pkg;
    // ==========================================================
    // Register offsets.
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_C = 8'h04;
    localparam logic [7:0] OFS_RATIO = 8'h08;
    localparam logic [7:0] OFS_ISR = 8'h0c;
    localparam logic [7:0] OFS_IMR = 8'h10;
    localparam logic [7:0] OFS_TIMER = 8'h14;
    localparam logic [7:0] OFS_COMPARE = 8'h18;
    localparam logic [7:0] OFS_ZCAP = 8'h1c;
    localparam logic [7:0] OFS_ZPREV = 8'h20;
    localparam logic [7:0] OFS_WEIGHT = 8'h24;
    localparam logic [7:0] OFS_DEMAG = 8'h28;
    localparam logic [7:0] OFS_PRELOAD = 8'h2c;
    // ==========================================================
    // Field positions.
    localparam int CA_CLK_EN = 0;
    localparam int CA_AUTO = 1;
    localparam int CA_DSRC = 2;
    localparam int CC_SOFT_COMM = 0;
    localparam int CC_OVF = 1;
    localparam int CC_TES_LO = 2;
    localparam int CC_SOFT_ZC = 4;
    localparam int CC_ZC_SEEN = 5;
    localparam int IS_COMM = 0;
    localparam int IS_RINC = 1;
    localparam int IS_RDEC = 2;
    localparam int IM_COMM = 0;
    localparam int IM_RATIO = 1;
    // ==========================================================
    // Reset values and thresholds.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_RATIO = 4'h0;
    localparam logic [3:0] RATIO_MAX = 4'hf;
    localparam logic [7:0] TIMER_MAX = 8'hff;
    localparam logic [7:0] TIMER_MEDIAN = 8'h80;
    localparam logic [7:0] TIMER_SLOW = 8'h55;
endpackage

// ---- rtl/commutation_delay_timer.sv ----
// Commutation delay timer with APB register access.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module commutation_delay_timer
    import delay_timer_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events from the input detection stage.
    input wire logic zero_cross_evt,
    // Motor control outputs.
    output logic commutation_pulse,
    output logic [7:0] active_config,
    output logic irq
);
    // ==========================================================
    // State.
    logic clk_en_reg, clk_en_next;
    logic auto_reg, auto_next;
    logic dsrc_reg, dsrc_next;
    logic soft_comm_reg, soft_comm_next;
    logic soft_zc_reg, soft_zc_next;
    logic ovf_reg, ovf_next;
    logic zc_seen_reg, zc_seen_next;
    logic [1:0] tes_reg, tes_next;
    logic [3:0] ratio_reg, ratio_next;
    logic ci_reg, ci_next;
    logic rinc_reg, rinc_next;
    logic rdec_reg, rdec_next;
    logic cim_reg, cim_next;
    logic rim_reg, rim_next;
    logic [7:0] timer_reg, timer_next;
    logic [7:0] compare_reg, compare_next;
    logic [7:0] zcap_reg, zcap_next;
    logic [7:0] zprev_reg, zprev_next;
    logic [7:0] weight_reg, weight_next;
    logic [7:0] demag_reg, demag_next;
    logic [7:0] preload_reg, preload_next;
    logic [7:0] active_reg, active_next;
    logic armed_reg, armed_next;
    logic zs_armed_reg, zs_armed_next;
    logic [14:0] div_reg, div_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic comm_pulse_reg, comm_pulse_next;
    logic irq_reg, irq_next;

    // ==========================================================
    // Combinational terms.
    logic wr, setup, mapped, tick, at_max, cmp_on, comm_evt, z_hw, z_sim, z_evt;
    logic ratio_hw, recompute;
    logic [15:0] div_span;
    logic [15:0] product;
    logic [7:0] rdata;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && pready_reg;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_PRELOAD);
    // Larger ratios stretch the count period by powers of two.
    assign div_span = (16'h0001 << ratio_reg) - 16'h0001;
    assign tick = clk_en_reg && (div_reg == div_span[14:0]);
    assign at_max = tick && (timer_reg == TIMER_MAX);
    // With soft commutation the compare waits for a fresh write.
    assign cmp_on = (soft_comm_reg || auto_reg) ? armed_reg : 1'b1;
    assign comm_evt = clk_en_reg && cmp_on && (compare_reg <= timer_reg);
    assign z_hw = clk_en_reg && auto_reg && zero_cross_evt;
    assign z_sim = clk_en_reg && auto_reg && soft_zc_reg && zs_armed_reg && (zcap_reg <= timer_reg);
    assign z_evt = z_hw || z_sim;

    always_comb begin
        rdata = 8'h00;
        case (paddr)
            OFS_CTRL_A: rdata = {5'h0, dsrc_reg, auto_reg, clk_en_reg};
            OFS_CTRL_C: rdata = {2'h0, zc_seen_reg, soft_zc_reg, tes_reg, ovf_reg, soft_comm_reg};
            OFS_RATIO: rdata = {4'h0, ratio_reg};
            OFS_ISR: rdata = {5'h0, rdec_reg, rinc_reg, ci_reg};
            OFS_IMR: rdata = {6'h0, rim_reg, cim_reg};
            OFS_TIMER: rdata = timer_reg;
            OFS_COMPARE: rdata = compare_reg;
            OFS_ZCAP: rdata = zcap_reg;
            OFS_ZPREV: rdata = zprev_reg;
            OFS_WEIGHT: rdata = weight_reg;
            OFS_DEMAG: rdata = demag_reg;
            OFS_PRELOAD: rdata = preload_reg;
            default: rdata = 8'h00;
        endcase
    end

    always_comb begin
        clk_en_next = clk_en_reg;
        auto_next = auto_reg;
        dsrc_next = dsrc_reg;
        soft_comm_next = soft_comm_reg;
        soft_zc_next = soft_zc_reg;
        ovf_next = ovf_reg;
        zc_seen_next = zc_seen_reg;
        tes_next = tes_reg;
        ratio_next = ratio_reg;
        ci_next = ci_reg;
        rinc_next = rinc_reg;
        rdec_next = rdec_reg;
        cim_next = cim_reg;
        rim_next = rim_reg;
        timer_next = timer_reg;
        compare_next = compare_reg;
        zcap_next = zcap_reg;
        zprev_next = zprev_reg;
        weight_next = weight_reg;
        demag_next = demag_reg;
        preload_next = preload_reg;
        active_next = active_reg;
        armed_next = armed_reg;
        zs_armed_next = zs_armed_reg;
        div_next = tick ? 15'h0 : (clk_en_reg ? div_reg + 15'h1 : 15'h0);
        ratio_hw = 1'b0;
        recompute = 1'b0;
        product = 16'h0;
        pready_next = setup;
        prdata_next = setup ? {24'h000000, rdata} : prdata_reg;
        pslverr_next = setup && !mapped;
        comm_pulse_next = comm_evt;
        // Software first, so that hardware events below win over clears.
        if (wr && mapped) begin
            case (paddr)
                OFS_CTRL_A: begin
                    clk_en_next = pwdata[CA_CLK_EN];
                    auto_next = pwdata[CA_AUTO];
                    dsrc_next = pwdata[CA_DSRC];
                end
                OFS_CTRL_C: begin
                    soft_comm_next = pwdata[CC_SOFT_COMM];
                    ovf_next = ovf_reg && pwdata[CC_OVF];
                    tes_next = pwdata[CC_TES_LO+:2];
                    soft_zc_next = pwdata[CC_SOFT_ZC];
                    zc_seen_next = zc_seen_reg && pwdata[CC_ZC_SEEN];
                    if (pwdata[CC_SOFT_COMM] && !soft_comm_reg) begin
                        armed_next = 1'b0;
                    end
                end
                OFS_RATIO: begin
                    if (!clk_en_reg) begin
                        ratio_next = pwdata[3:0];
                    end
                end
                OFS_ISR: begin
                    ci_next = ci_reg && pwdata[IS_COMM];
                    if (!(pwdata[IS_RINC] && pwdata[IS_RDEC])) begin
                        rinc_next = pwdata[IS_RINC];
                        rdec_next = pwdata[IS_RDEC];
                    end
                end
                OFS_IMR: begin
                    cim_next = pwdata[IM_COMM];
                    rim_next = pwdata[IM_RATIO];
                end
                OFS_TIMER: begin
                    if (!clk_en_reg) begin
                        timer_next = pwdata[7:0];
                    end
                end
                OFS_COMPARE: begin
                    if (!clk_en_reg || soft_comm_reg || !auto_reg) begin
                        compare_next = pwdata[7:0];
                        armed_next = 1'b1;
                    end
                end
                OFS_ZCAP: begin
                    zcap_next = pwdata[7:0];
                    zs_armed_next = 1'b1;
                end
                OFS_ZPREV: begin
                    if (!clk_en_reg) begin
                        zprev_next = pwdata[7:0];
                    end
                end
                OFS_WEIGHT: weight_next = pwdata[7:0];
                OFS_DEMAG: demag_next = pwdata[7:0];
                OFS_PRELOAD: preload_next = pwdata[7:0];
                default: ;
            endcase
        end
        if (z_hw) begin
            zc_seen_next = 1'b1;
        end
        // Counting and overflow.
        if (tick) begin
            timer_next = timer_reg + 8'h01;
            if (at_max) begin
                if (tes_reg == 2'b00) begin
                    ovf_next = 1'b1;
                end
                if (auto_reg && ratio_reg != RATIO_MAX) begin
                    ratio_next = ratio_reg + 4'h1;
                    ratio_hw = 1'b1;
                    timer_next = TIMER_MEDIAN;
                    compare_next = {1'b0, compare_reg[7:1]};
                    zcap_next = {1'b0, zcap_reg[7:1]};
                    zprev_next = {1'b0, zprev_reg[7:1]};
                    demag_next = {1'b0, demag_reg[7:1]};
                    rinc_next = 1'b1;
                    recompute = 1'b1;
                end else begin
                    timer_next = 8'h00;
                end
            end
        end
        // Commutation.
        if (comm_evt) begin
            active_next = preload_reg;
            ci_next = 1'b1;
            compare_next = timer_reg;
            armed_next = 1'b0;
            if (!auto_reg) begin
                timer_next = 8'h00;
                if (rinc_reg && ratio_reg != RATIO_MAX) begin
                    ratio_next = ratio_reg + 4'h1;
                    ratio_hw = 1'b1;
                    compare_next = {1'b0, compare_reg[7:1]};
                    zcap_next = {1'b0, zcap_reg[7:1]};
                    zprev_next = {1'b0, zprev_reg[7:1]};
                    demag_next = {1'b0, demag_reg[7:1]};
                end else if (rdec_reg && ratio_reg != RST_RATIO) begin
                    ratio_next = ratio_reg - 4'h1;
                    ratio_hw = 1'b1;
                    compare_next = {compare_reg[6:0], 1'b0};
                    zcap_next = {zcap_reg[6:0], 1'b0};
                    zprev_next = {zprev_reg[6:0], 1'b0};
                    demag_next = {demag_reg[6:0], 1'b0};
                end
                rinc_next = 1'b0;
                rdec_next = 1'b0;
            end
        end
        // Zero crossing; only the autoswitched timer reacts to it.
        if (z_evt) begin
            timer_next = 8'h00;
            zprev_next = zcap_reg;
            zs_armed_next = 1'b0;
            if (z_hw) begin
                zcap_next = timer_reg;
            end
            recompute = 1'b1;
            if (timer_reg < TIMER_SLOW && ratio_reg != RST_RATIO) begin
                ratio_next = ratio_reg - 4'h1;
                ratio_hw = 1'b1;
                zcap_next = z_hw ? {timer_reg[6:0], 1'b0} : {zcap_reg[6:0], 1'b0};
                zprev_next = {zcap_reg[6:0], 1'b0};
                demag_next = {demag_reg[6:0], 1'b0};
                rdec_next = 1'b1;
            end
        end
        // The multiply is redone after each crossing or automatic ratio raise, unless soft commutation is on.
        if (recompute && !soft_comm_reg) begin
            product = weight_reg * (dsrc_reg ? zcap_next : zprev_next);
            compare_next = product[15:8];
            armed_next = 1'b1;
        end
        irq_next = (ci_next && cim_reg) || ((rinc_next || rdec_next) && rim_reg);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_en_reg <= 1'b0;
            auto_reg <= 1'b0;
            dsrc_reg <= 1'b0;
            soft_comm_reg <= 1'b0;
            soft_zc_reg <= 1'b0;
            ovf_reg <= 1'b0;
            zc_seen_reg <= 1'b0;
            tes_reg <= 2'b00;
            ratio_reg <= RST_RATIO;
            ci_reg <= 1'b0;
            rinc_reg <= 1'b0;
            rdec_reg <= 1'b0;
            cim_reg <= 1'b0;
            rim_reg <= 1'b0;
            timer_reg <= RST_BYTE;
            compare_reg <= RST_BYTE;
            zcap_reg <= RST_BYTE;
            zprev_reg <= RST_BYTE;
            weight_reg <= RST_BYTE;
            demag_reg <= RST_BYTE;
            preload_reg <= RST_BYTE;
            active_reg <= RST_BYTE;
            armed_reg <= 1'b0;
            zs_armed_reg <= 1'b0;
            div_reg <= 15'h0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            comm_pulse_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            clk_en_reg <= clk_en_next;
            auto_reg <= auto_next;
            dsrc_reg <= dsrc_next;
            soft_comm_reg <= soft_comm_next;
            soft_zc_reg <= soft_zc_next;
            ovf_reg <= ovf_next;
            zc_seen_reg <= zc_seen_next;
            tes_reg <= tes_next;
            ratio_reg <= ratio_next;
            ci_reg <= ci_next;
            rinc_reg <= rinc_next;
            rdec_reg <= rdec_next;
            cim_reg <= cim_next;
            rim_reg <= rim_next;
            timer_reg <= timer_next;
            compare_reg <= compare_next;
            zcap_reg <= zcap_next;
            zprev_reg <= zprev_next;
            weight_reg <= weight_next;
            demag_reg <= demag_next;
            preload_reg <= preload_next;
            active_reg <= active_next;
            armed_reg <= armed_next;
            zs_armed_reg <= zs_armed_next;
            div_reg <= div_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            comm_pulse_reg <= comm_pulse_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign commutation_pulse = comm_pulse_reg;
    assign active_config = active_reg;
    assign irq = irq_reg;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic quiet;
    assign quiet = !(wr && mapped);

    a_switch_clear: assert property (!auto_reg && comm_evt |=> timer_reg == 8'h00)
        else $error("switched commutation did not clear timer");
    a_comm_flag: assert property (comm_evt |=> ci_reg && commutation_pulse && active_config == $past(preload_reg))
        else $error("commutation flag or preload missing");
    a_ratio_lock: assert property (clk_en_reg && !ratio_hw |=> ratio_reg == $past(ratio_reg))
        else $error("ratio changed while running");
    a_both_ignored: assert property (wr && paddr == OFS_ISR && pwdata[IS_RINC] && pwdata[IS_RDEC] && !comm_evt
        && !at_max && !z_evt |=> rinc_reg == $past(rinc_reg) && rdec_reg == $past(rdec_reg))
        else $error("double ratio write took effect");
    a_switch_zc_quiet: assert property (!auto_reg && tick && !comm_evt && !at_max && quiet
        |=> timer_reg == $past(timer_reg) + 8'h01)
        else $error("switched timer disturbed");
    a_overflow_wrap: assert property (!auto_reg && at_max && !comm_evt && tes_reg == 2'b00
        |=> timer_reg == 8'h00 && ovf_reg)
        else $error("switched overflow wrong");
    a_auto_hold: assert property (auto_reg && comm_evt && !z_evt && !tick && quiet
        |=> timer_reg == $past(timer_reg))
        else $error("autoswitched commutation moved timer");
    a_zc_capture: assert property (z_hw && timer_reg >= TIMER_SLOW && quiet
        |=> zcap_reg == $past(timer_reg) && zprev_reg == $past(zcap_reg) && timer_reg == 8'h00)
        else $error("zero crossing capture wrong");
    a_auto_inc: assert property (auto_reg && at_max && ratio_reg != RATIO_MAX && !z_evt
        |=> timer_reg == TIMER_MEDIAN && rinc_reg && ratio_reg == $past(ratio_reg) + 4'h1)
        else $error("automatic increment wrong");
    a_max_hold: assert property (auto_reg && at_max && ratio_reg == RATIO_MAX && !z_evt
        |=> timer_reg == 8'h00 && ratio_reg == RATIO_MAX)
        else $error("maximum ratio overflow wrong");
    a_min_hold: assert property (z_evt && ratio_reg == RST_RATIO && quiet |=> ratio_reg == {3'h0, $past(at_max)})
        else $error("ratio dropped below zero");
    a_soft_wait: assert property (soft_comm_reg && !armed_reg |-> !comm_evt)
        else $error("soft commutation without write");

    c_switch_comm: cover property (!auto_reg && comm_evt);
    c_auto_inc: cover property (auto_reg && at_max && ratio_reg != RATIO_MAX);
    c_auto_dec: cover property (z_hw && timer_reg < TIMER_SLOW && ratio_reg != RST_RATIO);
    c_soft_comm: cover property (soft_comm_reg && comm_evt);
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the commutation delay timer.
`timescale 1ns/100ps
module tb
    import delay_timer_pkg::*;
;
    // ==========================================================
    // Design connections.
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic zero_cross_evt = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic commutation_pulse;
    logic [7:0] active_config;
    logic irq;
    int n_errors = 0;
    int n_checks = 0;
    int n_comm = 0;
    int c0 = 0;
    logic [7:0] q;
    logic e;
    logic [7:0] t1;

    always #50 ref_clk = ~ref_clk;

    // Commutation pulses stand one cycle, often while a bus transfer runs, so count them here.
    always @(posedge ref_clk) begin
        if (commutation_pulse === 1'b1) begin
            n_comm <= n_comm + 1;
        end
    end

    commutation_delay_timer i_commutation_delay_timer (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .zero_cross_evt(zero_cross_evt), .commutation_pulse(commutation_pulse),
        .active_config(active_config), .irq(irq)
    );

    // ==========================================================
    // Checking and bus tasks.
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic timed_out(input string name);
        n_errors++;
        $display("[FAIL] %s expected done seen timeout", name);
        give_verdict();
    endtask

    // The request stands until the rising edge at which ready is sampled high; data is taken at that edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) timed_out("apb ready");
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(name, q, exp);
    endtask

    task automatic pulse_zc();
        zero_cross_evt <= 1'b1;
        @(posedge ref_clk);
        zero_cross_evt <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wait_comm(input int c);
        int k;
        for (k = 0; k < 2000; k++) begin
            @(posedge ref_clk);
            if (n_comm >= c) break;
        end
        if (k == 2000) timed_out("commutation");
        @(posedge ref_clk);
    endtask

    task automatic poll(input logic [7:0] a, input logic [7:0] m, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            apb(1'b0, a, 8'h00);
            if ((q & m) === m) break;
        end
        if (k == lim) timed_out("status poll");
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdchk("timer after reset", OFS_TIMER, 8'h00);
        apb(1'b0, 8'h40, 8'h00);
        check("unmapped error", {7'h00, e}, 8'h01);
        check("unmapped data", q, 8'h00);
        // Switched mode: ratio flags, commutation with preload, shift on step change.
        wr(OFS_RATIO, 8'h00);
        wr(OFS_PRELOAD, 8'ha5);
        wr(OFS_IMR, 8'h01);
        wr(OFS_COMPARE, 8'h40);
        wr(OFS_ISR, 8'h06);
        rdchk("both flags from clear", OFS_ISR, 8'h00);
        wr(OFS_ISR, 8'h02);
        wr(OFS_ISR, 8'h06);
        rdchk("both flags keep increment", OFS_ISR, 8'h02);
        wr(OFS_CTRL_A, 8'h01);
        wr(OFS_RATIO, 8'h07);
        rdchk("ratio locked while running", OFS_RATIO, 8'h00);
        wait_comm(1);
        check("preload copied", active_config, 8'ha5);
        check("commutation irq", {7'h00, irq}, 8'h01);
        rdchk("status after commutation", OFS_ISR, 8'h01);
        rdchk("ratio stepped up", OFS_RATIO, 8'h01);
        rdchk("compare halved", OFS_COMPARE, 8'h20);
        apb(1'b0, OFS_TIMER, 8'h00);
        t1 = q;
        check("timer cleared at match", {7'h00, q < 8'h10}, 8'h01);
        pulse_zc();
        apb(1'b0, OFS_TIMER, 8'h00);
        check("crossing leaves timer", {7'h00, q >= t1}, 8'h01);
        // Autoswitched mode with soft commutation, then hardware crossings.
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_ISR, 8'h00);
        wr(OFS_CTRL_C, 8'h01);
        wr(OFS_RATIO, 8'h0f);
        wr(OFS_TIMER, 8'h60);
        wr(OFS_ZCAP, 8'h33);
        wr(OFS_WEIGHT, 8'h80);
        wr(OFS_CTRL_A, 8'h07);
        c0 = n_comm;
        repeat (10) @(posedge ref_clk);
        check("no commutation before compare write", n_comm[7:0], c0[7:0]);
        wr(OFS_COMPARE, 8'h10);
        wait_comm(c0 + 1);
        rdchk("late compare overwritten", OFS_COMPARE, 8'h60);
        rdchk("timer kept at commutation", OFS_TIMER, 8'h60);
        wr(OFS_COMPARE, 8'h20);
        wait_comm(c0 + 2);
        check("second soft commutation", n_comm[7:0], c0[7:0] + 8'h02);
        wr(OFS_CTRL_C, 8'h00);
        pulse_zc();
        rdchk("capture of timer", OFS_ZCAP, 8'h60);
        rdchk("previous capture", OFS_ZPREV, 8'h33);
        rdchk("timer cleared by crossing", OFS_TIMER, 8'h00);
        rdchk("computed compare", OFS_COMPARE, 8'h30);
        pulse_zc();
        rdchk("ratio stepped down", OFS_RATIO, 8'h0e);
        apb(1'b0, OFS_ISR, 8'h00);
        check("decrement flag", q & 8'h04, 8'h04);
        // Bottom and top of the step ratio range.
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_ISR, 8'h00);
        wr(OFS_RATIO, 8'h00);
        wr(OFS_TIMER, 8'h10);
        wr(OFS_IMR, 8'h02);
        wr(OFS_CTRL_A, 8'h07);
        pulse_zc();
        rdchk("ratio held at zero", OFS_RATIO, 8'h00);
        apb(1'b0, OFS_ISR, 8'h00);
        check("no decrement flag at zero", q & 8'h04, 8'h00);
        poll(OFS_ISR, 8'h02, 200);
        rdchk("ratio raised on full count", OFS_RATIO, 8'h01);
        apb(1'b0, OFS_CTRL_C, 8'h00);
        check("overflow flag on raise", q & 8'h02, 8'h02);
        check("ratio irq", {7'h00, irq}, 8'h01);
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_ISR, 8'h00);
        wr(OFS_CTRL_C, 8'h00);
        wr(OFS_RATIO, 8'h0f);
        wr(OFS_TIMER, 8'hff);
        wr(OFS_CTRL_A, 8'h07);
        poll(OFS_CTRL_C, 8'h02, 12000);
        rdchk("ratio held at top", OFS_RATIO, 8'h0f);
        rdchk("timer wrapped", OFS_TIMER, 8'h00);
        apb(1'b0, OFS_ISR, 8'h00);
        check("no increment flag at top", q & 8'h02, 8'h00);
        check("no irq at top", {7'h00, irq}, 8'h00);
        give_verdict();
    end
endmodule
